//--- rtl/host_regs_defines.svh
`ifndef HOST_REGS_DEFINES_SVH
`define HOST_REGS_DEFINES_SVH

// ----------------------------------------------------------------
// host port byte addresses
// ----------------------------------------------------------------
`define RA_DATA_MASK 8'he0
`define RA_DATA_BASE 8'h00
`define RA_STAT_POP  8'h40
`define RA_STAT_PEEK 8'h44
`define RA_RSVD      8'h48
`define RA_ID        8'h50
`define RA_CFG       8'h54
`define RA_KEEP      8'h58
`define RA_STS       8'h5c
`define RA_FLUSH     8'h60

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CFG_SRST_BIT 31
`define FLUSH_D_BIT  0
`define FLUSH_S_BIT  1
`define STS_W1C_MASK 4'h1
`define KEEP_RST     32'h00000000

`endif

//--- rtl/host_regs_pkg.sv
package host_regs_pkg;

  // which source answers a pending read
  typedef enum logic [2:0] {
    SEL_CSR  = 3'b001,
    SEL_DATA = 3'b010,
    SEL_STAT = 3'b100
  } rsel_t;

endpackage

//--- rtl/fifo_if.sv
`timescale 1ns/1ps

interface fifo_if #(
  parameter int W  = 32,
  parameter int AW = 4
);
  logic          push;
  logic [W-1:0]  wdata;
  logic          pop;
  logic          peek;
  logic          flush;
  logic [AW:0]   cap;
  logic [W-1:0]  rdata;
  logic [AW:0]   count;
  logic          full;
  logic          drop;

  modport ctl (output push, wdata, pop, peek, flush, cap,
               input  rdata, count, full, drop);
  modport mem (input  push, wdata, pop, peek, flush, cap,
               output rdata, count, full, drop);
endinterface

//--- rtl/rx_fifo.sv
`timescale 1ns/1ps

module rx_fifo #(
  parameter int W  = 32,  // entry width
  parameter int AW = 4    // address bits, depth is 2**AW
) (
  input  wire logic clk,   // device clock
  input  wire logic nrst,  // sync reset, active low
  fifo_if.mem       port   // control side
);
  localparam int DEPTH = 1 << AW;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             count;
    logic [W-1:0]            rdata;
  } st_t;

  st_t  st_r;
  st_t  st_nxt;
  logic full;
  logic do_push;
  logic do_pop;

  always_comb
  begin
    st_nxt  = st_r;
    // capacity is programmable below the physical depth
    full    = (st_r.count >= port.cap) ||
              (st_r.count == (AW+1)'(DEPTH));
    do_push = port.push && !full;
    do_pop  = port.pop && (st_r.count != '0);
    if (port.pop || port.peek)
      st_nxt.rdata = (st_r.count != '0) ? st_r.mem[st_r.rptr] : '0;
    if (do_push)
    begin
      st_nxt.mem[st_r.wptr] = port.wdata;
      st_nxt.wptr           = st_r.wptr + 1'b1;
    end
    if (do_pop)
      st_nxt.rptr = st_r.rptr + 1'b1;
    st_nxt.count = st_r.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (port.flush)
    begin
      st_nxt.wptr  = '0;
      st_nxt.rptr  = '0;
      st_nxt.count = '0;
    end
  end

  always_ff @(posedge clk)
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;

  assign port.rdata = st_r.rdata;
  assign port.count = st_r.count;
  assign port.full  = full;
  assign port.drop  = port.push && full;

  pop_removes_a: assert property (
    @(posedge clk) disable iff (!nrst)
    port.pop && !port.push && !port.flush && st_r.count != '0
    |=> st_r.count == $past(st_r.count) - 1'b1)
    else $error("pop did not remove exactly one entry");

  peek_keeps_a: assert property (
    @(posedge clk) disable iff (!nrst)
    port.peek && !port.pop && !port.push && !port.flush
    |=> st_r.count == $past(st_r.count) &&
        st_r.rptr == $past(st_r.rptr))
    else $error("peek changed the fifo");
endmodule

//--- rtl/event_flags.sv
`timescale 1ns/1ps

module event_flags #(
  parameter int           N        = 4,    // number of flags
  parameter logic [N-1:0] W1C_MASK = '0    // set: cleared by write one
) (
  input  wire logic         clk,       // device clock
  input  wire logic         nrst,      // sync reset, active low
  input  wire logic         soft_rst,  // soft reset cycle
  input  wire logic [N-1:0] cond,      // condition to latch
  input  wire logic         rd,        // read of the holding register
  input  wire logic         wr,        // write of the holding register
  input  wire logic [N-1:0] wbits,     // write data
  output logic      [N-1:0] flags      // latched flags
);
  typedef struct packed {
    logic [N-1:0] flag;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    for (int i = 0; i < N; i++)
    begin
      if (W1C_MASK[i])
        st_nxt.flag[i] = cond[i] | (st_r.flag[i] & ~(wr & wbits[i]));
      else
        st_nxt.flag[i] = cond[i] | (st_r.flag[i] & ~rd);
    end
    if (soft_rst)
      st_nxt = '0;
  end

  always_ff @(posedge clk)
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;

  assign flags = st_r.flag;

  w1c_clear_a: assert property (
    @(posedge clk) disable iff (!nrst)
    wr && !soft_rst
    |=> (st_r.flag & $past(wbits) & W1C_MASK & ~$past(cond)) == '0)
    else $error("write one did not clear flag");

  rd_clear_a: assert property (
    @(posedge clk) disable iff (!nrst)
    rd && !soft_rst |=> (st_r.flag & ~W1C_MASK & ~$past(cond)) == '0)
    else $error("read did not clear flag");

  latch_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !rd && !wr && !soft_rst
    |=> (st_r.flag & $past(st_r.flag)) == $past(st_r.flag))
    else $error("latched flag lost before read");
endmodule

//--- rtl/host_regs.sv
// Function
// - host writes to read-only registers and fields change nothing
// - reads of the write-only register always return zero
// - writing one clears a write-one-clear bit, zero leaves it
// - read-clear bits clear as a side effect of reading
// - latch bits hold their condition until the register is read
// - the reset-exempt register survives a soft reset
// - the hard reset reloads all registers with their defaults
// - both receive fifos are read-only ports
// - status pop port returns the oldest entry and removes it
// - status peek port returns the oldest entry, keeps it
// - every data port read pops the oldest word, returning only its low half on a 16-bit bus
// - all data port alias addresses behave alike, each popping
// - fifo capacities come from control register fields
`timescale 1ns/1ps
`include "host_regs_defines.svh"

module host_regs #(
  parameter int          AW_D   = 6,            // data fifo addr bits
  parameter int          AW_S   = 4,            // status fifo addr bits
  parameter logic [31:0] ID_VAL = 32'h5a5a0001  // arbitrary value
) (
  input  wire logic        clk,          // 40 MHz device clock
  input  wire logic        nrst,         // sync reset, active low
  input  wire logic        host_cs,      // host select
  input  wire logic        host_rd,      // read strobe, one cycle
  input  wire logic        host_wr,      // write strobe, one cycle
  input  wire logic [7:0]  host_addr,    // byte address
  input  wire logic [31:0] host_wdata,   // write data
  input  wire logic        bus16,        // 16-bit bus strap pin
  input  wire logic        rxd_valid,    // receive data word push
  input  wire logic [31:0] rxd_data,     // receive data word
  input  wire logic        rxs_valid,    // receive status push
  input  wire logic [31:0] rxs_data,     // receive status word
  input  wire logic        link_up,      // link level
  input  wire logic        fault_evt,    // fault condition
  output logic      [31:0] host_rdata,   // read data
  output logic             host_rvalid,  // read data valid pulse
  output logic             soft_rst_o    // soft reset pulse to core
);
  localparam logic [7:0] DCAP_DEF = 8'(1 << AW_D);
  localparam logic [7:0] SCAP_DEF = 8'(1 << AW_S);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 m16_s1;
    logic                 m16_s2;
    logic [7:0]           dcap;
    logic [7:0]           scap;
    logic                 srst;
    logic [31:0]          keep;
    logic                 pend;
    logic                 pend16;
    host_regs_pkg::rsel_t rsel;
    logic [31:0]          csr_q;
    logic [31:0]          rdata;
    logic                 rvalid;
  } st_t;

  st_t         st_r;
  st_t         st_nxt;
  logic        rd;
  logic        wr;
  logic        data_hit;
  logic        stat_hit;
  logic        sts_rd;
  logic        sts_wr;
  logic [3:0]  fl;
  logic [3:0]  fl_cond;
  logic [31:0] sts_val;
  logic [31:0] csr_val;

  fifo_if #(.W(32), .AW(AW_D)) d_if ();
  fifo_if #(.W(32), .AW(AW_S)) s_if ();

  // ----------------------------------------------------------------
  // host decode
  // ----------------------------------------------------------------
  // a read wins when both strobes come together
  assign rd       = host_cs && host_rd;
  assign wr       = host_cs && host_wr && !host_rd;
  assign data_hit = (host_addr & `RA_DATA_MASK) == `RA_DATA_BASE;
  assign stat_hit = (host_addr == `RA_STAT_POP) ||
                    (host_addr == `RA_STAT_PEEK);
  assign sts_rd   = rd && (host_addr == `RA_STS);
  assign sts_wr   = wr && (host_addr == `RA_STS);

  // ----------------------------------------------------------------
  // receive fifos
  // ----------------------------------------------------------------
  // only the receive side pushes
  assign d_if.push  = rxd_valid;
  assign d_if.wdata = rxd_data;
  assign d_if.pop   = rd && data_hit;
  assign d_if.peek  = 1'b0;
  assign d_if.flush = st_r.srst ||
                      (wr && host_addr == `RA_FLUSH &&
                       host_wdata[`FLUSH_D_BIT]);
  // capacity from config
  // values above the depth act as the depth rather than wrapping
  assign d_if.cap   = (st_r.dcap > DCAP_DEF) ? (AW_D+1)'(DCAP_DEF)
                                             : st_r.dcap[AW_D:0];

  assign s_if.push  = rxs_valid;
  assign s_if.wdata = rxs_data;
  assign s_if.pop   = rd && (host_addr == `RA_STAT_POP);
  assign s_if.peek  = rd && (host_addr == `RA_STAT_PEEK);
  assign s_if.flush = st_r.srst ||
                      (wr && host_addr == `RA_FLUSH &&
                       host_wdata[`FLUSH_S_BIT]);
  assign s_if.cap   = (st_r.scap > SCAP_DEF) ? (AW_S+1)'(SCAP_DEF)
                                             : st_r.scap[AW_S:0];

  rx_fifo #(.W(32), .AW(AW_D)) u_data_fifo (
    .clk  (clk),
    .nrst (nrst),
    .port (d_if)
  );

  rx_fifo #(.W(32), .AW(AW_S)) u_stat_fifo (
    .clk  (clk),
    .nrst (nrst),
    .port (s_if)
  );

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // bit 0 data overrun (write one clear), bit 1 status overrun
  // (read clear), bit 2 fault (latch high), bit 3 link down (latch low)
  assign fl_cond = {!link_up, fault_evt, s_if.drop, d_if.drop};

  event_flags #(.N(4), .W1C_MASK(`STS_W1C_MASK)) u_flags (
    .clk      (clk),
    .nrst     (nrst),
    .soft_rst (st_r.srst),
    .cond     (fl_cond),
    .rd       (sts_rd),
    .wr       (sts_wr),
    .wbits    (host_wdata[3:0]),
    .flags    (fl)
  );

  assign sts_val = {8'h00, 8'(s_if.count), 8'(d_if.count),
                    4'h0, ~fl[3], fl[2:0]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt        = st_r;
    csr_val       = 32'h00000000;
    st_nxt.m16_s1 = bus16;
    st_nxt.m16_s2 = st_r.m16_s1;
    case (host_addr)
      `RA_ID:   csr_val = ID_VAL;
      `RA_CFG:  csr_val = {st_r.srst, 15'h0000, st_r.scap, st_r.dcap};
      `RA_KEEP: csr_val = st_r.keep;
      `RA_STS:  csr_val = sts_val;
      default:  csr_val = 32'h00000000;
    endcase

    // first stage: capture the source, fifo heads load meanwhile
    st_nxt.pend = rd;
    if (rd)
    begin
      st_nxt.pend16 = st_r.m16_s2;
      st_nxt.csr_q  = csr_val;
      if (data_hit)
        st_nxt.rsel = host_regs_pkg::SEL_DATA;
      else if (stat_hit)
        st_nxt.rsel = host_regs_pkg::SEL_STAT;
      else
        st_nxt.rsel = host_regs_pkg::SEL_CSR;
    end

    // second stage: drive the answer
    st_nxt.rvalid = st_r.pend;
    if (st_r.pend)
    begin
      unique case (st_r.rsel)
        host_regs_pkg::SEL_DATA:
          st_nxt.rdata = st_r.pend16 ? {16'h0000, d_if.rdata[15:0]}
                                     : d_if.rdata;
        host_regs_pkg::SEL_STAT:
          st_nxt.rdata = s_if.rdata;
        host_regs_pkg::SEL_CSR:
          st_nxt.rdata = st_r.csr_q;
      endcase
    end

    st_nxt.srst = 1'b0;
    if (wr && host_addr == `RA_CFG && !st_r.srst)
    begin
      st_nxt.dcap = host_wdata[7:0];
      st_nxt.scap = host_wdata[15:8];
      st_nxt.srst = host_wdata[`CFG_SRST_BIT];
    end
    if (wr && host_addr == `RA_KEEP)
      st_nxt.keep = host_wdata;
    if (st_r.srst)
    begin
      st_nxt.dcap = DCAP_DEF;
      st_nxt.scap = SCAP_DEF;
    end
  end

  always_ff @(posedge clk)
    if (!nrst)
    begin
      st_r      <= '0;
      st_r.dcap <= DCAP_DEF;
      st_r.scap <= SCAP_DEF;
      st_r.keep <= `KEEP_RST;
      st_r.rsel <= host_regs_pkg::SEL_CSR;
    end
    else
      st_r <= st_nxt;

  assign host_rdata  = st_r.rdata;
  assign host_rvalid = st_r.rvalid;
  assign soft_rst_o  = st_r.srst;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ro_write_a: assert property (
    sts_wr && fl[2] && !st_r.srst |=> fl[2])
    else $error("write changed a read-only status bit");

  wo_read_zero_a: assert property (
    rd && host_addr == `RA_FLUSH |-> ##2 host_rvalid && host_rdata == 0)
    else $error("write-only register did not read zero");

  keep_survives_a: assert property (
    st_r.srst && !(wr && host_addr == `RA_KEEP)
    |=> st_r.keep == $past(st_r.keep))
    else $error("exempt register lost value in soft reset");

  soft_defaults_a: assert property (
    st_r.srst |=> st_r.dcap == DCAP_DEF && st_r.scap == SCAP_DEF &&
                  d_if.count == 0 && s_if.count == 0)
    else $error("soft reset did not reload defaults");

  fifo_ro_a: assert property (
    wr && (data_hit || stat_hit) && !rxd_valid && !rxs_valid &&
    !st_r.srst
    |=> d_if.count == $past(d_if.count) &&
        s_if.count == $past(s_if.count))
    else $error("write changed a receive fifo");

  alias_pop_a: assert property (
    rd && data_hit && d_if.count != 0 && !rxd_valid && !st_r.srst
    |=> d_if.count == $past(d_if.count) - 1'b1)
    else $error("data alias read did not pop one word");

  cap_limit_a: assert property (
    d_if.full |=> d_if.count <= $past(d_if.count))
    else $error("data fifo grew past its capacity");

  srst_self_clear_a: assert property (
    st_r.srst |=> !st_r.srst)
    else $error("soft reset bit did not clear itself");

  rd_answer_a: assert property (
    rd |=> st_r.pend ##1 host_rvalid)
    else $error("read not answered two cycles later");
endmodule

//--- bench/host_model.sv
`timescale 1ns/1ps
`include "host_regs_defines.svh"

module host_model (
  input  wire logic        clk,     // device clock
  output logic             cs,      // host select
  output logic             rd,      // read strobe
  output logic             wr,      // write strobe
  output logic [7:0]       addr,    // byte address
  output logic [31:0]      wdata,   // write data
  input  wire logic [31:0] rdata,   // read data
  input  wire logic        rvalid   // read answer pulse
);
  initial
  begin
    cs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'hff;
    wdata = 32'hffffffff;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // released lines flip so a stale value is never mistaken for data
  task automatic release_bus();
    cs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = ~addr;
    wdata = ~wdata;
  endtask

  function automatic logic [31:0] defined_bits(input logic [7:0] a,
                                               input logic [31:0] d);
    case (a)
      `RA_CFG:   return d & 32'h8000ffff;
      `RA_STS:   return d & 32'h00000001;
      `RA_FLUSH: return d & 32'h00000003;
      default:   return d;
    endcase
  endfunction

  task automatic write(input logic [7:0] a, input logic [31:0] d);
    if (a != `RA_RSVD)
    begin
      @(negedge clk);
      cs = 1'b1;
      wr = 1'b1;
      addr = a;
      wdata = defined_bits(a, d);
      @(negedge clk);
      release_bus();
    end
  endtask

  // one-cycle strobe, answer awaited for a bounded number of cycles
  task automatic read(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(negedge clk);
    cs = 1'b1;
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    release_bus();
    d = 'x;
    for (n = 0; n < 4; n++)
    begin
      @(negedge clk);
      if (rvalid === 1'b1)
      begin
        d = rdata;
        n = 4;
      end
    end
  endtask
endmodule

//--- bench/host_register_fifo_access_tb_top.sv
`timescale 1ns/1ps
`include "host_regs_defines.svh"
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end

module host_register_fifo_access_tb_top;
  localparam logic [31:0] ID_V = 32'h00c0ffee;  // arbitrary value

  logic        clk, nrst, cs, rd, wr, bus16, b16;
  logic        rxd_valid, rxs_valid, link_up, fault_evt;
  logic        host_rvalid, soft_rst_o, ovd, ovs, flt, lnk;
  logic [7:0]  addr;
  logic [31:0] wdata, rxd_data, rxs_data, host_rdata, k;
  logic [31:0] dq[$];
  logic [31:0] sq[$];
  int          bad_count, total_checks, cycles, i, dcap, scap;

  host_regs #(.AW_D(3), .AW_S(2), .ID_VAL(ID_V)) DUT (
    .clk(clk), .nrst(nrst), .host_cs(cs), .host_rd(rd), .host_wr(wr),
    .host_addr(addr), .host_wdata(wdata), .bus16(bus16),
    .rxd_valid(rxd_valid), .rxd_data(rxd_data), .rxs_valid(rxs_valid),
    .rxs_data(rxs_data), .link_up(link_up), .fault_evt(fault_evt),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .soft_rst_o(soft_rst_o));

  host_model host (
    .clk(clk), .cs(cs), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata),
    .rdata(host_rdata), .rvalid(host_rvalid));

  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] sts_v();
    return {8'h00, 8'(sq.size()), 8'(dq.size()), 4'h0, lnk, flt, ovs, ovd};
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.read(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask

  // read clears the status overrun and fault flags, the link flag reloads
  task automatic chk_sts();
    chk_reg(`RA_STS, sts_v());
    ovs = 1'b0;
    flt = 1'b0;
    lnk = link_up;
  endtask

  task automatic rd_data(input logic [7:0] a);
    logic [31:0] d, e;
    e = (dq.size() > 0) ? dq.pop_front() : 32'h0;
    if (b16)
      e = {16'h0, e[15:0]};
    host.read(a, d);
    `CHK("data port", e, d)
  endtask

  task automatic rd_stat(input logic [7:0] a);
    logic [31:0] d, e;
    e = (sq.size() > 0) ? sq[0] : 32'h0;
    if (a == `RA_STAT_POP && sq.size() > 0)
      void'(sq.pop_front());
    host.read(a, d);
    `CHK("status port", e, d)
  endtask

  // a full fifo drops the entry and raises its overrun flag
  task automatic push(input bit st, input logic [31:0] w);
    @(negedge clk);
    rxs_valid = st;
    rxd_valid = !st;
    rxs_data = w;
    rxd_data = w;
    @(negedge clk);
    rxs_valid = 1'b0;
    rxd_valid = 1'b0;
    rxs_data = ~w;
    rxd_data = ~w;
    if (st && sq.size() < scap)
      sq.push_back(w);
    else if (st)
      ovs = 1'b1;
    else if (dq.size() < dcap)
      dq.push_back(w);
    else
      ovd = 1'b1;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    bus16 = 1'b0;
    b16 = 1'b0;
    rxd_valid = 1'b0;
    rxs_valid = 1'b0;
    rxd_data = 32'h0;
    rxs_data = 32'h0;
    link_up = 1'b1;
    fault_evt = 1'b0;
    {ovd, ovs, flt, lnk} = 4'h1;
    dcap = 8;
    scap = 4;
    void'($urandom(91109));
    repeat (2) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    chk_reg(`RA_CFG, 32'h00000408);
    chk_reg(`RA_KEEP, `KEEP_RST);
    chk_sts();
    host.write(`RA_ID, $urandom());
    chk_reg(`RA_ID, ID_V);
    host.write(`RA_DATA_BASE, $urandom());
    host.write(`RA_STAT_POP, $urandom());
    chk_sts();
    // fifos are empty here, so a random flush pattern is harmless
    host.write(`RA_FLUSH, $urandom());
    chk_reg(`RA_FLUSH, 32'h0);
    rd_data(`RA_DATA_BASE);
    rd_stat(`RA_STAT_POP);
    for (i = 0; i < 9; i++)
      push(1'b0, $urandom());
    for (i = 0; i < 3; i++)
      push(1'b1, $urandom());
    chk_sts();
    rd_stat(`RA_STAT_PEEK);
    rd_stat(`RA_STAT_PEEK);
    host.write(`RA_STS, 32'h0);
    chk_sts();
    host.write(`RA_STS, 32'h1);
    ovd = 1'b0;
    chk_sts();
    for (i = 0; i < 3; i++)
      rd_stat(`RA_STAT_POP);
    for (i = 0; i < 8; i++)
      rd_data(8'(4 * i));
    chk_sts();
    bus16 = 1'b1;
    b16 = 1'b1;
    repeat (3) @(negedge clk);
    for (i = 0; i < 16; i++)
    begin
      push(1'b0, $urandom());
      rd_data(8'(2 * i));
    end
    bus16 = 1'b0;
    b16 = 1'b0;
    repeat (3) @(negedge clk);
    host.write(`RA_CFG, 32'h00000102);
    dcap = 2;
    scap = 1;
    chk_reg(`RA_CFG, 32'h00000102);
    for (i = 0; i < 3; i++)
      push(1'b0, $urandom());
    for (i = 0; i < 2; i++)
      push(1'b1, $urandom());
    chk_sts();
    chk_sts();
    @(negedge clk);
    fault_evt = 1'b1;
    @(negedge clk);
    fault_evt = 1'b0;
    link_up = 1'b0;
    @(negedge clk);
    link_up = 1'b1;
    {flt, lnk} = 2'b10;
    // a status write while the fault latch is set must leave it alone
    host.write(`RA_STS, 32'h0);
    chk_sts();
    chk_sts();
    k = $urandom();
    host.write(`RA_KEEP, k);
    // the write returns in the cycle right after its strobe edge
    host.write(`RA_CFG, 32'h80000000);
    `CHK("soft reset", 1'b1, soft_rst_o)
    @(negedge clk);
    `CHK("soft reset", 1'b0, soft_rst_o)
    dq.delete();
    sq.delete();
    {ovd, ovs, flt, lnk} = 4'h1;
    dcap = 8;
    scap = 4;
    chk_reg(`RA_CFG, 32'h00000408);
    chk_reg(`RA_KEEP, k);
    chk_sts();
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chk_reg(`RA_KEEP, `KEEP_RST);
    results();
  end
endmodule
